// ==== hw/mst_pkg.sv ====
package mst_pkg;

   // register map
   localparam logic [7:0] PROTO_CTRL_OFFSET = 8'h50;
   localparam logic [7:0] FRAME_STATS_OFFSET = 8'h54;
   localparam logic [31:0] PROTO_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] PROTO_CTRL_WRITABLE = 32'h0007_F900;
   localparam logic [31:0] FRAME_STATS_RESET = 32'h0000_0000;

   // field positions in protocol_snoop_control
   localparam int unsigned IGMP_DEST_IP_CHECK_BIT = 8;
   localparam int unsigned IGMP_QUERY_SNOOP_BIT = 11;
   localparam int unsigned IGMP_QUERY_TRAP_BIT = 12;
   localparam int unsigned IGMP_OTHER_SNOOP_BIT = 13;
   localparam int unsigned IGMP_OTHER_TRAP_BIT = 14;
   localparam int unsigned MLD_REPORT_SNOOP_BIT = 15;
   localparam int unsigned MLD_REPORT_TRAP_BIT = 16;
   localparam int unsigned MLD_QUERY_SNOOP_BIT = 17;
   localparam int unsigned MLD_QUERY_TRAP_BIT = 18;

   // protocol numbers and message types
   localparam logic [7:0] IP_PROTO_IGMP = 8'h02;
   localparam logic [7:0] IPV6_NEXT_ICMPV6 = 8'h3A;
   localparam logic [3:0] CLASS_D_PREFIX = 4'hE;
   localparam logic [7:0] IGMP_TYPE_QUERY = 8'h11;
   localparam logic [7:0] IGMP_TYPE_REPORT_V1 = 8'h12;
   localparam logic [7:0] IGMP_TYPE_REPORT_V2 = 8'h16;
   localparam logic [7:0] IGMP_TYPE_LEAVE = 8'h17;
   localparam logic [7:0] IGMP_TYPE_REPORT_V3 = 8'h22;
   localparam logic [7:0] MLD_TYPE_QUERY = 8'h82;
   localparam logic [7:0] MLD_TYPE_REPORT_V1 = 8'h83;
   localparam logic [7:0] MLD_TYPE_DONE = 8'h84;
   localparam logic [7:0] MLD_TYPE_REPORT_V2 = 8'h8F;

   // ports: bit CPU_PORT of a mask is the management cpu port
   localparam int unsigned PORT_COUNT = 7;
   localparam int unsigned CPU_PORT = 6;
   localparam int unsigned STAT_WIDTH = 16;

   typedef logic [PORT_COUNT-1:0] mst_mask_type;

   typedef enum logic [2:0] {
      MST_CLASS_NONE = 3'b000,
      MST_CLASS_IGMP_QUERY = 3'b001,
      MST_CLASS_IGMP_OTHER = 3'b010,
      MST_CLASS_MLD_QUERY = 3'b011,
      MST_CLASS_MLD_REPORT = 3'b100
   } mst_class_type;

   typedef struct packed {
      logic is_ipv4;
      logic is_ipv6;
      logic [7:0] ip_proto;
      logic [31:0] dest_ip;
      logic [7:0] msg_type;
      mst_mask_type l2_mask;
   } mst_desc_type;

   typedef struct packed {
      mst_mask_type port_mask;
      logic cpu_copy;
      logic trapped;
      mst_class_type frame_class;
   } mst_verdict_type;

endpackage : mst_pkg

// ==== hw/mst_classifier.sv ====
`timescale 1ns/1ps
module mst_classifier (
   // frame header summary
   input wire mst_pkg::mst_desc_type desc,
   // control fields
   input wire logic [31:0] ctrl,
   // decision
   output mst_pkg::mst_verdict_type verdict
);

   wire logic is_igmp;
   wire logic is_mld;
   wire logic class_d;
   wire logic igmp_known;
   wire logic mld_report;
   wire logic snoop_on;
   wire logic trap_only;
   wire mst_pkg::mst_class_type frame_class;
   wire mst_pkg::mst_mask_type cpu_mask;
   wire mst_pkg::mst_mask_type port_mask;

   assign class_d = desc.dest_ip[31:28] == mst_pkg::CLASS_D_PREFIX;
   assign is_igmp = desc.is_ipv4 && desc.ip_proto == mst_pkg::IP_PROTO_IGMP
      && (!ctrl[mst_pkg::IGMP_DEST_IP_CHECK_BIT] || class_d);
   assign is_mld = desc.is_ipv6 && desc.ip_proto == mst_pkg::IPV6_NEXT_ICMPV6;
   // report and leave are known types handled by fields outside this block
   assign igmp_known = desc.msg_type == mst_pkg::IGMP_TYPE_REPORT_V1
      || desc.msg_type == mst_pkg::IGMP_TYPE_REPORT_V2
      || desc.msg_type == mst_pkg::IGMP_TYPE_REPORT_V3
      || desc.msg_type == mst_pkg::IGMP_TYPE_LEAVE;
   assign mld_report = desc.msg_type == mst_pkg::MLD_TYPE_REPORT_V1
      || desc.msg_type == mst_pkg::MLD_TYPE_REPORT_V2
      || desc.msg_type == mst_pkg::MLD_TYPE_DONE;

   assign frame_class =
      (is_igmp && desc.msg_type == mst_pkg::IGMP_TYPE_QUERY) ? mst_pkg::MST_CLASS_IGMP_QUERY :
      (is_igmp && !igmp_known) ? mst_pkg::MST_CLASS_IGMP_OTHER :
      (is_mld && desc.msg_type == mst_pkg::MLD_TYPE_QUERY) ? mst_pkg::MST_CLASS_MLD_QUERY :
      (is_mld && mld_report) ? mst_pkg::MST_CLASS_MLD_REPORT :
      mst_pkg::MST_CLASS_NONE;

   assign snoop_on =
      (frame_class == mst_pkg::MST_CLASS_IGMP_QUERY
         && ctrl[mst_pkg::IGMP_QUERY_SNOOP_BIT])
      || (frame_class == mst_pkg::MST_CLASS_IGMP_OTHER
         && ctrl[mst_pkg::IGMP_OTHER_SNOOP_BIT])
      || (frame_class == mst_pkg::MST_CLASS_MLD_QUERY
         && ctrl[mst_pkg::MLD_QUERY_SNOOP_BIT])
      || (frame_class == mst_pkg::MST_CLASS_MLD_REPORT
         && ctrl[mst_pkg::MLD_REPORT_SNOOP_BIT]);

   assign trap_only = snoop_on && (
      (frame_class == mst_pkg::MST_CLASS_IGMP_QUERY && ctrl[mst_pkg::IGMP_QUERY_TRAP_BIT])
      || (frame_class == mst_pkg::MST_CLASS_IGMP_OTHER
         && ctrl[mst_pkg::IGMP_OTHER_TRAP_BIT])
      || (frame_class == mst_pkg::MST_CLASS_MLD_QUERY
         && ctrl[mst_pkg::MLD_QUERY_TRAP_BIT])
      || (frame_class == mst_pkg::MST_CLASS_MLD_REPORT
         && ctrl[mst_pkg::MLD_REPORT_TRAP_BIT]));

   assign cpu_mask = mst_pkg::mst_mask_type'(1) << mst_pkg::CPU_PORT;

   assign port_mask = trap_only ? cpu_mask :
      snoop_on ? (desc.l2_mask | cpu_mask) : desc.l2_mask;
   // one assignment, so the output variable keeps a single driver
   assign verdict = {port_mask, snoop_on && !trap_only, trap_only, frame_class};

endmodule : mst_classifier

// ==== hw/mst_buffer.sv ====
`timescale 1ns/1ps
module mst_buffer #(
   parameter int unsigned WIDTH = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   // slot 0 is the head, so the output is a plain flop
   logic [WIDTH-1:0] mem [2];
   logic [1:0] held;
   logic [1:0] next_held;

   wire logic push = in_valid && in_ready;
   wire logic pop = held[0] && out_ready;

   assign next_held = pop ? (push ? held : {1'b0, held[1]}) : push ? {held[0], 1'b1} : held;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held <= 2'b00;
         in_ready <= 1'b1;
         mem[0] <= '0;
         mem[1] <= '0;
      end else begin
         held <= next_held;
         // ready only while the tail slot stays free; registered so the port is a flop
         in_ready <= !next_held[1];
         if (pop) begin
            mem[0] <= held[1] ? mem[1] : in_data;
            if (held[1]) begin
               mem[1] <= in_data;
            end
         end else if (push) begin
            if (held[0]) begin
               mem[1] <= in_data;
            end else begin
               mem[0] <= in_data;
            end
         end
      end
   end

   assign out_valid = held[0];
   assign out_data = mem[0];

endmodule : mst_buffer

// ==== hw/mst_snoop_top.sv ====
`timescale 1ns/1ps
module mst_snoop_top #(
   parameter int unsigned STAT_WIDTH = mst_pkg::STAT_WIDTH
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // frames from switch ports
   input wire logic in_valid,
   output logic in_ready,
   input wire mst_pkg::mst_desc_type in_desc,
   // decisions toward ports and cpu port
   output logic out_valid,
   input wire logic out_ready,
   output mst_pkg::mst_verdict_type out_verdict
);

   logic [31:0] ctrl;
   logic [STAT_WIDTH-1:0] trap_count;
   logic [STAT_WIDTH-1:0] copy_count;
   logic [31:0] next_prdata;
   logic next_pslverr;

   mst_pkg::mst_verdict_type verdict;

   wire logic setup = psel && !penable;
   wire logic access = psel && penable && pready;
   wire logic hit_ctrl = paddr == mst_pkg::PROTO_CTRL_OFFSET;
   wire logic hit_stats = paddr == mst_pkg::FRAME_STATS_OFFSET;
   wire logic accepted = in_valid && in_ready;
   wire logic [31:0] stats_word = {trap_count, copy_count};

   mst_classifier u_classifier (
      .desc(in_desc),
      .ctrl(ctrl),
      .verdict(verdict)
   );

   mst_buffer #(
      .WIDTH($bits(mst_pkg::mst_verdict_type))
   ) u_buffer (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(in_valid),
      .in_ready(in_ready),
      .in_data(verdict),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_verdict)
   );

   // upper bits are not stored, so they read back as zero
   assign next_prdata = hit_ctrl ? ctrl : hit_stats ? stats_word : 32'h0000_0000;
   assign next_pslverr = !(hit_ctrl || hit_stats);

   // answer one cycle after setup: zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         prdata <= setup ? next_prdata : prdata;
         pslverr <= setup && next_pslverr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= mst_pkg::PROTO_CTRL_RESET;
      end else if (access && pwrite && hit_ctrl) begin
         ctrl <= pwdata & mst_pkg::PROTO_CTRL_WRITABLE;
      end
   end

   // saturating so software never sees a wrapped count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trap_count <= '0;
         copy_count <= '0;
      end else if (access && pwrite && hit_stats) begin
         // an event in the clearing cycle is kept, not lost
         trap_count <= {{(STAT_WIDTH-1){1'b0}}, accepted && verdict.trapped};
         copy_count <= {{(STAT_WIDTH-1){1'b0}}, accepted && verdict.cpu_copy};
      end else if (accepted) begin
         if (verdict.trapped && !(&trap_count)) begin
            trap_count <= trap_count + 1'b1;
         end
         if (verdict.cpu_copy && !(&copy_count)) begin
            copy_count <= copy_count + 1'b1;
         end
      end
   end

endmodule : mst_snoop_top

// ==== testbench/mst_snoop_top_properties.sv ====
`timescale 1ns/1ps
module mst_snoop_top_checker (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // stream
   input wire logic in_valid,
   input wire logic in_ready,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire mst_pkg::mst_verdict_type out_verdict
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_setup_answer: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   chk_pready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
      else $error("refused read not zero");
   chk_take_answer: assert property (in_valid && in_ready |=> out_valid)
      else $error("taken frame gave no decision");
   chk_full_refuse: assert property (!in_ready |-> out_valid)
      else $error("refusing while empty");
   chk_hold_stall: assert property (out_valid && !out_ready |=> out_valid && $stable(out_verdict))
      else $error("decision dropped in stall");
   chk_trap_cpu_only: assert property (
      out_valid && out_verdict.trapped |-> out_verdict.port_mask == 7'h40)
      else $error("trap not cpu only");
   chk_copy_adds_cpu: assert property (
      out_valid && out_verdict.cpu_copy |-> out_verdict.port_mask[6] && !out_verdict.trapped)
      else $error("copy without cpu port");
   chk_plain_untouched: assert property (
      out_valid && out_verdict.frame_class == mst_pkg::MST_CLASS_NONE
      |-> !out_verdict.trapped && !out_verdict.cpu_copy)
      else $error("unclassified frame trapped or copied");
endmodule : mst_snoop_top_checker

// ==== testbench/mst_port_model.sv ====
`timescale 1ns/1ps
module mst_port_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // stall request
   input wire logic stall,
   // decision stream
   input wire logic out_valid,
   output logic out_ready,
   input wire mst_pkg::mst_verdict_type out_verdict
);
   mst_pkg::mst_verdict_type got[$];
   // a stalled sink lets the two-entry buffer fill
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_ready <= 1'b0;
      end else begin
         out_ready <= !stall;
         if (out_valid && out_ready) got.push_back(out_verdict);
      end
   end
endmodule : mst_port_model

// ==== testbench/mst_snoop_top_tb_top.sv ====
`timescale 1ns/1ps
module mst_snoop_top_tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic in_valid, in_ready, out_valid, out_ready, stall;
   mst_pkg::mst_desc_type in_desc;
   mst_pkg::mst_verdict_type out_verdict, v;
   int fail_count = 0;
   int num_checks = 0;
   logic [7:0] types [4] = '{mst_pkg::IGMP_TYPE_QUERY, 8'h30, mst_pkg::MLD_TYPE_QUERY,
      mst_pkg::MLD_TYPE_DONE};
   int unsigned sb [4] = '{mst_pkg::IGMP_QUERY_SNOOP_BIT, mst_pkg::IGMP_OTHER_SNOOP_BIT,
      mst_pkg::MLD_QUERY_SNOOP_BIT, mst_pkg::MLD_REPORT_SNOOP_BIT};

   mst_snoop_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .in_valid, .in_ready, .in_desc, .out_valid, .out_ready, .out_verdict);
   mst_port_model m_u (.pclk, .presetn, .stall, .out_valid, .out_ready, .out_verdict);

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : stop_test

   task cmp(input string what, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask : cmp

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // request stands until pready is seen high at a rising edge
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task send(input mst_pkg::mst_desc_type d);
      in_valid <= 1'b1;
      in_desc <= d;
      do begin
         @(posedge pclk);
      end while (in_ready !== 1'b1);
   endtask : send

   task pop;
      for (int n = 0; n < 100 && m_u.got.size() == 0; n++) @(posedge pclk);
      cmp("decision arrived", 1, m_u.got.size() != 0);
      if (m_u.got.size() != 0) v = m_u.got.pop_front();
   endtask : pop

   function automatic mst_pkg::mst_desc_type fr(input int c, input logic [6:0] l2);
      fr.is_ipv4 = (c < 2);
      fr.is_ipv6 = (c >= 2);
      fr.ip_proto = (c < 2) ? mst_pkg::IP_PROTO_IGMP : mst_pkg::IPV6_NEXT_ICMPV6;
      fr.dest_ip = 32'hE000_0001;
      fr.msg_type = types[c];
      fr.l2_mask = l2;
   endfunction : fr

   task test_regs;
      apb(1'b0, mst_pkg::PROTO_CTRL_OFFSET, 32'h0000_0000);
      // reserved bits 31:19 are disregarded on read and written as zero
      cmp("ctrl reset", mst_pkg::PROTO_CTRL_RESET, rd & 32'h0007_FFFF);
      apb(1'b1, mst_pkg::PROTO_CTRL_OFFSET, 32'h0007_FFFF);
      apb(1'b0, mst_pkg::PROTO_CTRL_OFFSET, 32'h0000_0000);
      cmp("ctrl bits", mst_pkg::PROTO_CTRL_WRITABLE, rd & 32'h0007_FFFF);
      cmp("ctrl err", 0, err);
      apb(1'b1, 8'h60, 32'hFFFF_FFFF);
      cmp("unmapped err", 1, err);
      apb(1'b0, 8'h60, 32'h0000_0000);
      cmp("unmapped data", 0, rd);
      $display("test_regs done");
   endtask : test_regs

   task test_classes;
      logic [31:0] cv;
      logic [6:0] em;
      mst_pkg::mst_desc_type d;
      for (int c = 0; c < 4; c++) begin
         for (int m = 0; m < 3; m++) begin
            cv = 32'h0000_0000;
            if (m != 2) cv[sb[c] + 1] = 1'b1;
            if (m != 0) cv[sb[c]] = 1'b1;
            apb(1'b1, mst_pkg::PROTO_CTRL_OFFSET, cv);
            send(fr(c, 7'h05));
            in_valid <= 1'b0;
            pop;
            em = (m == 0) ? 7'h05 : (m == 1) ? 7'h40 : 7'h45;
            cmp("mask", em, v.port_mask);
            cmp("trapped", m == 1, v.trapped);
            cmp("copy", m == 2, v.cpu_copy);
            if (m != 0) cmp("class", c + 1, v.frame_class);
         end
      end
      // destination check on: protocol 6 and a unicast destination are plain
      apb(1'b1, mst_pkg::PROTO_CTRL_OFFSET, 32'h0000_0900);
      for (int k = 0; k < 4; k++) begin
         d = fr(0, 7'h05);
         if (k == 0) d.ip_proto = 8'h06;
         if (k == 1 || k == 3) d.dest_ip = 32'h0A00_0001;
         // with the check off a unicast destination still counts
         if (k == 3) apb(1'b1, mst_pkg::PROTO_CTRL_OFFSET, 32'h0000_0800);
         send(d);
         in_valid <= 1'b0;
         pop;
         cmp("igmp match", (k >= 2) ? 7'h45 : 7'h05, v.port_mask);
      end
      $display("test_classes done");
   endtask : test_classes

   task test_stall;
      apb(1'b1, mst_pkg::PROTO_CTRL_OFFSET, 32'h0000_0800);
      apb(1'b1, mst_pkg::FRAME_STATS_OFFSET, 32'h0000_0000);
      stall <= 1'b1;
      send(fr(0, 7'h01));
      send(fr(0, 7'h02));
      in_desc <= fr(0, 7'h03);
      repeat (3) begin
         @(negedge pclk);
         cmp("in_ready full", 0, in_ready);
      end
      @(posedge pclk);
      stall <= 1'b0;
      send(fr(0, 7'h03));
      in_valid <= 1'b0;
      for (int k = 1; k < 4; k++) begin
         pop;
         cmp("order", 7'h40 | k, v.port_mask);
      end
      // three copied frames since the clear, none trapped
      apb(1'b0, mst_pkg::FRAME_STATS_OFFSET, 32'h0000_0000);
      cmp("stats", 32'h0000_0003, rd);
      $display("test_stall done");
   endtask : test_stall

   task test_reset;
      apb(1'b1, mst_pkg::PROTO_CTRL_OFFSET, 32'h0007_F900);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, mst_pkg::PROTO_CTRL_OFFSET, 32'h0000_0000);
      cmp("ctrl after reset", mst_pkg::PROTO_CTRL_RESET, rd & 32'h0007_FFFF);
      cmp("ready after reset", 1, in_ready);
      send(fr(0, 7'h05));
      in_valid <= 1'b0;
      pop;
      cmp("mask after reset", 7'h05, v.port_mask);
      $display("test_reset done");
   endtask : test_reset

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, in_valid, in_desc, stall} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      test_regs;
      test_classes;
      test_stall;
      test_reset;
      stop_test;
   end

   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      stop_test;
   end
endmodule : mst_snoop_top_tb_top

bind mst_snoop_top mst_snoop_top_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
   .prdata, .pready, .pslverr, .in_valid, .in_ready, .out_valid, .out_ready, .out_verdict);
